//--- logic/adccap_buf.sv
// two-entry result buffer with valid/ready on both sides
// assumes a synchronous active-high reset and clock enable
`timescale 1ns/1ps
module adccap_buf #(
  parameter int W = 14
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  adccap_stream_if.snk in_s,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic rd_r, rd_nxt, wr_r, wr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign in_s.ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];
  always_comb begin
    push = in_s.valid && in_s.ready;
    pop = out_valid && out_ready;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wr_r] = in_s.data;
    end
    wr_nxt = push ? ~wr_r : wr_r;
    rd_nxt = pop ? ~rd_r : rd_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (clk_en) begin
      mem_r <= mem_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

//--- logic/adccap_ctrl.sv
// How it works
// - start each conversion with a falling strobe
// - strobe returns high well within 420 ns
// - no strobe edges while converting
// - offset binary inverts only the top bit
// - capture word on data ready rising edge
// - power-down defaults inactive (pin high); read and select default active
//
// controller that strobes the converter and captures its parallel results
// assumes pins from the converter are asynchronous; wishbone classic slave on ref_clk
`timescale 1ns/1ps
`include "adccap_regs.svh"
module adccap_ctrl import adccap_pkg::*; #(
  parameter int W = 14,
  parameter logic [15:0] TIMEOUT = `ADCCAP_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic conversion_start_strobe,
  output logic power_down_control,
  output logic read_strobe_n,
  output logic chip_select_n,
  input wire logic data_ready,
  input wire logic [W-1:0] result_word
);
  localparam logic [7:0] LOW_CYC = 8'(`ADCCAP_LOW_CYC);
  // three-stage synchronisers; stage 0 feeds only stage 1
  logic [2:0] rdy_s0_r;
  logic [W-1:0] dat_s0_r, dat_s1_r, dat_s2_r;
  logic rdy_seen_r, rdy_seen_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [15:0] period_r, period_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  adccap_state_t st_r, st_nxt;
  logic strobe_r, strobe_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic ovr_r, ovr_nxt, tmo_r, tmo_nxt;
  logic rdy_rise, bus_req, pop;
  logic out_valid;
  logic [W-1:0] out_data;
  adccap_stream_if #(.W(W)) cap_s ();
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return old;
  endfunction
  function automatic logic [31:0] fmt(input logic [W-1:0] w, input logic offs);
    logic [W-1:0] v;
    v = w;
    if (offs) begin
      v[W-1] = ~w[W-1];
    end
    return {{(32-W){v[W-1] & ~offs}}, v};
  endfunction
  adccap_buf #(.W(W)) u_buf (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_s(cap_s.snk),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_ready(pop)
  );
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdy_s0_r <= 3'h0;
      dat_s0_r <= '0;
      dat_s1_r <= '0;
      dat_s2_r <= '0;
    end else if (clk_en) begin
      rdy_s0_r <= {rdy_s0_r[1:0], data_ready};
      dat_s0_r <= result_word;
      dat_s1_r <= dat_s0_r;
      dat_s2_r <= dat_s1_r;
    end
  end
  always_comb begin
    // change counts once stages one and two agree
    rdy_rise = rdy_s0_r[1] && rdy_s0_r[2] && !rdy_seen_r;
    rdy_seen_nxt = (rdy_s0_r[1] == rdy_s0_r[2]) ? rdy_s0_r[1] : rdy_seen_r;
    cap_s.valid = rdy_rise && (st_r == ADCCAP_WAIT);
    cap_s.data = dat_s2_r; // word held stable since rising edge
  end
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    pop = bus_req && !wb_we_i && (wb_adr_i == `ADCCAP_ADDR_DATA) && out_valid;
    ctrl_nxt = ctrl_r;
    period_nxt = period_r;
    ovr_nxt = ovr_r || (rdy_rise && (st_r == ADCCAP_WAIT) && !cap_s.ready);
    tmo_nxt = tmo_r;
    rdat_nxt = rdat_r;
    ack_nxt = bus_req;
    if (bus_req && wb_we_i) begin
      case (wb_adr_i)
        `ADCCAP_ADDR_CTRL: ctrl_nxt = merge(ctrl_r, wb_dat_i, wb_sel_i);
        `ADCCAP_ADDR_PERIOD: period_nxt = 16'(merge({16'h0, period_r}, wb_dat_i, wb_sel_i));
        `ADCCAP_ADDR_STATUS: begin
          // write one clears; a new event in the same cycle wins
          if (wb_sel_i[0] && wb_dat_i[`ADCCAP_STAT_OVERRUN]) begin
            ovr_nxt = rdy_rise && (st_r == ADCCAP_WAIT) && !cap_s.ready;
          end
          if (wb_sel_i[0] && wb_dat_i[`ADCCAP_STAT_TIMEOUT]) begin
            tmo_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `ADCCAP_ADDR_CTRL: rdat_nxt = ctrl_r;
        `ADCCAP_ADDR_STATUS: rdat_nxt = {28'h0, tmo_r, ovr_r, out_valid, st_r != ADCCAP_IDLE};
        `ADCCAP_ADDR_DATA: rdat_nxt = out_valid ? fmt(out_data, ctrl_r[`ADCCAP_CTRL_OFFSET_BIN]) : 32'h0;
        `ADCCAP_ADDR_PERIOD: rdat_nxt = {16'h0, period_r};
        default: rdat_nxt = 32'h0;
      endcase
    end
    if (st_r == ADCCAP_IDLE && ctrl_r[`ADCCAP_CTRL_SINGLE]) begin
      ctrl_nxt[`ADCCAP_CTRL_SINGLE] = 1'b0;
    end
    if (st_r == ADCCAP_WAIT && cnt_r == TIMEOUT) begin
      tmo_nxt = 1'b1;
    end
  end
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 16'h1;
    strobe_nxt = strobe_r;
    case (st_r)
      ADCCAP_IDLE: begin
        cnt_nxt = 16'h0;
        if (ctrl_r[`ADCCAP_CTRL_RUN] || ctrl_r[`ADCCAP_CTRL_SINGLE]) begin
          strobe_nxt = 1'b0;
          st_nxt = ADCCAP_LOW;
        end
      end
      ADCCAP_LOW: begin
        if (cnt_r[7:0] >= LOW_CYC - 8'h1) begin
          strobe_nxt = 1'b1; // back high before 420 ns
          st_nxt = ADCCAP_WAIT;
          cnt_nxt = 16'h0;
        end
      end
      ADCCAP_WAIT: begin
        // strobe stays high; wait ends on data ready or timeout
        if (rdy_rise || cnt_r == TIMEOUT) begin
          st_nxt = ADCCAP_GAP;
          cnt_nxt = 16'h0;
        end
      end
      ADCCAP_GAP: begin
        if (cnt_r >= period_r) begin
          st_nxt = ADCCAP_IDLE;
        end
      end
      default: begin
        st_nxt = ADCCAP_IDLE;
        strobe_nxt = 1'b1;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= `ADCCAP_CTRL_RESET;
      period_r <= `ADCCAP_PERIOD_RESET;
      st_r <= ADCCAP_IDLE;
      cnt_r <= 16'h0;
      strobe_r <= 1'b1;
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
      ovr_r <= 1'b0;
      tmo_r <= 1'b0;
      rdy_seen_r <= 1'b0;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      period_r <= period_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      strobe_r <= strobe_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      ovr_r <= ovr_nxt;
      tmo_r <= tmo_nxt;
      rdy_seen_r <= rdy_seen_nxt;
    end
  end
  // pin outputs straight from flops; select/read levels are active low on the pins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      conversion_start_strobe <= 1'b1;
      power_down_control <= 1'b1;
      read_strobe_n <= 1'b0;
      chip_select_n <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (clk_en) begin
      conversion_start_strobe <= strobe_nxt;
      power_down_control <= ctrl_nxt[`ADCCAP_CTRL_POWER_UP];
      read_strobe_n <= ~ctrl_nxt[`ADCCAP_CTRL_READ_EN];
      chip_select_n <= ~ctrl_nxt[`ADCCAP_CTRL_SELECT];
      wb_ack_o <= ack_nxt;
      wb_dat_o <= rdat_nxt;
    end
  end
endmodule

//--- logic/adccap_pkg.sv
// state type of the capture controller; the result buffer does not use it
// assumes adccap_regs.svh constants
package adccap_pkg;
  typedef enum logic [3:0] {
    ADCCAP_IDLE = 4'b0001,
    ADCCAP_LOW = 4'b0010,
    ADCCAP_WAIT = 4'b0100,
    ADCCAP_GAP = 4'b1000
  } adccap_state_t;
endpackage

//--- logic/adccap_regs.svh
// register map, field positions and timing constants of the capture controller
// assumes a 50 MHz ref_clk and a 32-bit classic wishbone slave port
`ifndef ADCCAP_REGS_SVH
`define ADCCAP_REGS_SVH
`define ADCCAP_ADDR_CTRL 4'h0
`define ADCCAP_ADDR_STATUS 4'h4
`define ADCCAP_ADDR_DATA 4'h8
`define ADCCAP_ADDR_PERIOD 4'hc
`define ADCCAP_CTRL_RUN 0
`define ADCCAP_CTRL_SINGLE 1
`define ADCCAP_CTRL_OFFSET_BIN 2
`define ADCCAP_CTRL_POWER_UP 3
`define ADCCAP_CTRL_READ_EN 4
`define ADCCAP_CTRL_SELECT 5
`define ADCCAP_STAT_BUSY 0
`define ADCCAP_STAT_VALID 1
`define ADCCAP_STAT_OVERRUN 2
`define ADCCAP_STAT_TIMEOUT 3
`define ADCCAP_CTRL_RESET 32'h0000_0038
`define ADCCAP_PERIOD_RESET 16'h0064
`define ADCCAP_CLK_MHZ 50
`define ADCCAP_LOW_NS 400
`define ADCCAP_LOW_CYC ((`ADCCAP_LOW_NS * `ADCCAP_CLK_MHZ) / 1000)
`define ADCCAP_TIMEOUT_CYC 16'h1000
`endif

//--- logic/adccap_stream_if.sv
// valid/ready word stream between capture logic and result buffer
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface adccap_stream_if #(parameter int W = 14);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- tb/adccap_conv_model.sv
// converter model: latched result word and data ready
// assumes strobe edges come right after ref_clk edges
`timescale 1ns/1ps
module adccap_conv_model (
  input wire logic ref_clk,
  input wire logic conversion_start_strobe,
  input wire logic power_down_control,
  input wire logic [13:0] next_code,
  input wire logic [7:0] conv_cyc,
  output logic data_ready,
  output logic [13:0] result_word
);
  initial begin
    data_ready = 1'b0;
    result_word = 14'h0000;
  end
  always begin
    @(negedge conversion_start_strobe);
    @(posedge ref_clk);
    data_ready <= 1'b0;
    repeat (conv_cyc) @(posedge ref_clk);
    // shutdown never answers, so the controller must time out
    if (power_down_control) begin
      result_word <= next_code;
      @(posedge ref_clk);
      data_ready <= 1'b1;
    end
  end
endmodule

//--- tb/adccap_ctrl_assertions.sv
// port-level checks of the capture controller
// assumes clk_en held high by the bench
`timescale 1ns/1ps
module adccap_ctrl_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic conversion_start_strobe,
  input wire logic power_down_control,
  input wire logic read_strobe_n,
  input wire logic chip_select_n,
  input wire logic data_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_latency: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_reset_pins: assert property ($fell(reset) |-> conversion_start_strobe && power_down_control &&
    !read_strobe_n && !chip_select_n) else $error("pins not at defaults");
  a_strobe_low_time: assert property ($fell(conversion_start_strobe) |->
    ##19 !conversion_start_strobe ##1 conversion_start_strobe) else $error("strobe low time");
  a_strobe_quiet: assert property ($rose(conversion_start_strobe) |-> conversion_start_strobe [*8])
    else $error("strobe edge during conversion");
  a_ready_gap: assert property ($rose(data_ready) |-> conversion_start_strobe [*4])
    else $error("strobe right after ready");
  a_pins_by_write: assert property ($changed(power_down_control) || $changed(read_strobe_n) ||
    $changed(chip_select_n) |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
    else $error("control pin moved without write");
endmodule
bind adccap_ctrl adccap_ctrl_chk u_chk (.ref_clk, .reset, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .conversion_start_strobe, .power_down_control, .read_strobe_n, .chip_select_n, .data_ready);

//--- tb/test_adc_convert_and_capture.sv
// self-checking bench: wishbone master, converter model, random codes
// assumes the design files and the bound checker are compiled first
`timescale 1ns/1ps
`include "adccap_regs.svh"
module test_adc_convert_and_capture;
  logic ref_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ob;
  logic [3:0] adr = 0, sel = 4'hf;
  logic [31:0] wdat = 0, rdat;
  logic [31:0] dat_o;
  logic ack, strobe, pdc, rd_n, cs_n, rdy;
  logic [13:0] word, c, code = 0;
  logic [7:0] dly = 8'h20;
  logic [13:0] tab [3] = '{14'h2000, 14'h1fff, 14'h0000};
  int err_total = 0, num_checks = 0, seed = 32'hde7f, n;
  adccap_ctrl #(.W(14), .TIMEOUT(16'h0100)) uut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .conversion_start_strobe(strobe), .power_down_control(pdc),
    .read_strobe_n(rd_n), .chip_select_n(cs_n), .data_ready(rdy), .result_word(word));
  adccap_conv_model dev (.ref_clk(ref_clk), .conversion_start_strobe(strobe), .power_down_control(pdc),
    .next_code(code), .conv_cyc(dly), .data_ready(rdy), .result_word(word));
  initial forever #10 ref_clk = ~ref_clk;
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    i = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge ref_clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    rdat = dat_o;
    chk("ack", {31'h0, ack}, 1);
    if (ack !== 1'b1) stop_test;
    cyc <= 0; stb <= 0;
    @(posedge ref_clk);
  endtask
  task poll(input logic [31:0] m, input logic [31:0] x);
    int i;
    i = 0;
    do begin
      bus(0, `ADCCAP_ADDR_STATUS, 0);
      i++;
    end while ((rdat & m) !== x && i < 300);
    chk("status", rdat & m, x);
    if ((rdat & m) !== x) stop_test;
  endtask
  function automatic logic [31:0] exp_word(logic [13:0] k, logic o);
    return o ? {18'h0, ~k[13], k[12:0]} : {{18{k[13]}}, k};
  endfunction
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    bus(0, `ADCCAP_ADDR_CTRL, 0);
    chk("ctrl", rdat, 32'h38);
    bus(0, `ADCCAP_ADDR_PERIOD, 0);
    chk("period", rdat, 32'h64);
    bus(0, 4'h2, 0);
    chk("unmapped", rdat, 0);
    // an unmapped write must land nowhere
    bus(1, 4'h2, 32'hffff_ffff);
    bus(0, `ADCCAP_ADDR_CTRL, 0);
    chk("unmapped write", rdat, 32'h38);
    bus(0, `ADCCAP_ADDR_DATA, 0);
    chk("empty", rdat, 0);
    bus(1, `ADCCAP_ADDR_PERIOD, 32'h10);
    // byte enables: only the low byte may change
    sel <= 4'h1;
    bus(1, `ADCCAP_ADDR_PERIOD, 32'hffff_ff20);
    sel <= 4'hf;
    bus(0, `ADCCAP_ADDR_PERIOD, 0);
    chk("period bytes", rdat, 32'h20);
    $display("test reset done");
    for (n = 0; n < 12; n++) begin
      c = n < 6 ? tab[n % 3] : 14'($random(seed));
      ob = ((n / 3) % 2) == 1;
      code <= c;
      // prompt and slow answers, both inside the timeout
      dly <= 8'd25 + 8'($unsigned($random(seed)) % 120);
      poll(1, 0);
      bus(1, `ADCCAP_ADDR_CTRL, 32'h3a | {29'h0, ob, 2'b00});
      poll(2, 2);
      bus(0, `ADCCAP_ADDR_DATA, 0);
      chk("data", rdat, exp_word(c, ob));
    end
    $display("test codes done");
    poll(1, 0);
    bus(1, `ADCCAP_ADDR_CTRL, 32'h32);
    chk("shutdown", {31'h0, pdc}, 0);
    poll(8, 8);
    bus(1, `ADCCAP_ADDR_STATUS, 32'h8);
    bus(0, `ADCCAP_ADDR_STATUS, 0); chk("timeout clear", rdat & 8, 0);
    bus(1, `ADCCAP_ADDR_CTRL, 32'h08); chk("lines off", {30'h0, rd_n, cs_n}, 3);
    bus(1, `ADCCAP_ADDR_CTRL, 32'h38); chk("lines on", {30'h0, rd_n, cs_n}, 0);
    $display("test shutdown done");
    code <= 14'h1555;
    dly <= 8'd30;
    bus(1, `ADCCAP_ADDR_CTRL, 32'h39);
    poll(4, 4);
    bus(1, `ADCCAP_ADDR_CTRL, 32'h38);
    poll(1, 0);
    for (n = 0; n < 3; n++) begin
      bus(0, `ADCCAP_ADDR_DATA, 0); chk("drain", rdat, n < 2 ? 32'h1555 : 0);
    end
    bus(1, `ADCCAP_ADDR_STATUS, 32'h4);
    bus(0, `ADCCAP_ADDR_STATUS, 0); chk("overrun clear", rdat & 4, 0);
    $display("test overrun done");
    // mid-run reset with the read and select pins away from their defaults
    bus(1, `ADCCAP_ADDR_CTRL, 32'h08);
    reset <= 1;
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    chk("pins after reset", {29'h0, pdc, rd_n, cs_n}, 32'h4);
    bus(0, `ADCCAP_ADDR_CTRL, 0);
    chk("ctrl after reset", rdat, 32'h38);
    bus(0, `ADCCAP_ADDR_PERIOD, 0);
    chk("period after reset", rdat, 32'h64);
    $display("test reset again done");
    stop_test;
  end
endmodule
